// [bcw_pkg.sv]
// Purpose: shared constants and types for the bus-cycle wait controller
// Assumes: 100 MHz clock, jumper inputs are 1 when the jumper sits left (or top)
// Notes: wait counts are in whole clock periods
package bcw_pkg;

   localparam int          CLK_MHZ           = 100;
   localparam int          IO_RECOVERY_NS    = 500;
   localparam int          IO_RECOVERY_CYC   = (IO_RECOVERY_NS * CLK_MHZ + 999) / 1000;
   localparam int          CNT_W             = 6;
   localparam logic [1:0]  PORT_LATCH_OFS    = 2'h1;
   localparam logic [1:0]  PORT_STATUS_OFS   = 2'h3;
   localparam logic [7:0]  LATCH_RESET       = 8'h00;
   localparam logic [7:0]  RD_DATA_RESET     = 8'h00;
   localparam logic [CNT_W-1:0] EXTRA_READ_WAITS = 6'h02;
   localparam logic [CNT_W-1:0] CNT_ZERO     = 6'h00;
   localparam logic [CNT_W-1:0] CNT_ONE      = 6'h01;
   localparam logic [CNT_W-1:0] IO_RECOVERY_CNT = CNT_W'(IO_RECOVERY_CYC);

   typedef enum logic [1:0]
   {
      CYC_FETCH   = 2'b00,
      CYC_MEM_RD  = 2'b01,
      CYC_MEM_OTH = 2'b10,
      CYC_IO      = 2'b11
   } bcw_cycle_e;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01
   } bcw_state_e;

   typedef struct packed
   {
      logic       start;
      bcw_cycle_e kind;
   } bcw_cycle_s;

   typedef struct packed
   {
      logic       wait_a;
      logic       wait_b;
      logic       extra_read;
      logic       latch_clear;
      logic       io_recovery;
   } bcw_jumpers_s;

endpackage

// [bcw_down_counter.sv]
// Purpose: loadable down counter that reports when it has run out
// Assumes: load and count never matter in the same cycle, load wins
// Notes: holds at zero
`timescale 1ns/10ps
module bcw_down_counter
   import bcw_pkg::*;
(
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] load_value,
   output logic                  zero,
   output logic [CNT_W-1:0]      count
);

   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;

   assign zero       = (count_reg == CNT_ZERO);
   assign count      = count_reg;
   assign count_next = load ? load_value : (zero ? CNT_ZERO : count_reg - CNT_ONE);

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         count_reg <= CNT_ZERO;
      else
         count_reg <= count_next;
   end

endmodule

// [bcw_wait_control.sv]
// Purpose: wait-state insertion, I/O recovery and memory-manager latch control
// Assumes: cycle.start is a one-cycle pulse at the start of each bus cycle
// Notes: Notes on behaviour follows
// Notes on behaviour
// - fetch gets 0-2 waits, memory 0-1
// - two wait jumpers jointly pick fetch/memory waits
// - latch cleared at power-on and optional bus reset
// - extra option adds two waits to data reads
// - extra-read jumper left enables, right disables
// - I/O operations spaced by recovery interval
// - recovery jumper left enables, right disables
// - output to base plus one loads latch
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module bcw_wait_control
   import bcw_pkg::*;
(
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire bcw_cycle_s   cycle,
   input  wire logic         bus_wait_req,
   output logic              cycle_ready,
   output logic              cycle_busy,
   input  wire bcw_jumpers_s jumpers,
   input  wire logic         power_on_clear,
   input  wire logic         bus_reset_n,
   input  wire logic [5:0]   onboard_port_base,
   input  wire logic [7:0]   io_addr,
   input  wire logic [7:0]   io_wr_data,
   input  wire logic         io_wr,
   input  wire logic         io_rd,
   output logic [7:0]        io_rd_data,
   output logic [7:0]        mm_latch
);

   bcw_state_e       state_reg;
   bcw_state_e       state_next;
   bcw_cycle_e       kind_reg;
   logic [7:0]       latch_reg;
   logic [7:0]       rd_data_reg;
   logic [CNT_W-1:0] fetch_waits;
   logic [CNT_W-1:0] mem_waits;
   logic [CNT_W-1:0] base_waits;
   logic [CNT_W-1:0] cycle_waits;
   logic [CNT_W-1:0] recovery_left;
   logic             wait_zero;
   logic             recovery_zero;
   logic             recovery_load;
   logic             io_hold;
   logic             port_hit;
   logic             latch_write;
   logic             status_read;
   logic             latch_read;
   logic             latch_clear;
   logic             finish;
   logic             recovery_on_reg;

   // jumper a left adds a fetch and a memory wait, b left adds a fetch wait
   function automatic logic [CNT_W-1:0] waits_for(input logic a_left, input logic b_left, input logic is_fetch);
      logic [CNT_W-1:0] n;
      n = CNT_ZERO;
      if (is_fetch)
         n = CNT_W'(a_left) + CNT_W'(b_left);
      else
         n = CNT_W'(a_left);
      return n;
   endfunction

   assign fetch_waits = waits_for(jumpers.wait_a, jumpers.wait_b, 1'b1);
   assign mem_waits   = waits_for(jumpers.wait_a, jumpers.wait_b, 1'b0);

   // instruction fetches never see the extra read waits
   assign base_waits  = (cycle.kind == CYC_FETCH) ? fetch_waits :
                        (cycle.kind == CYC_IO)    ? CNT_ZERO : mem_waits;
   assign cycle_waits = (cycle.kind == CYC_MEM_RD && jumpers.extra_read) ?
                        base_waits + EXTRA_READ_WAITS : base_waits;

   // io held off until the previous io cycle's recovery has elapsed
   // jumper taken at cycle start, a move mid-cycle cannot cut a recovery short
   assign io_hold     = (kind_reg == CYC_IO) && recovery_on_reg && !recovery_zero;

   // waits are loaded at the cycle start only, later jumper moves do not disturb it
   bcw_down_counter u_wait
   (
      .clock      (clock),
      .rst_n      (rst_n),
      .load       (cycle.start && state_reg == ST_IDLE),
      .load_value (cycle_waits),
      .zero       (wait_zero),
      .count      ()
   );

   // ready stays low while any wait remains, one clock per wait
   assign finish      = (state_reg == ST_WAIT) && wait_zero && !io_hold && !bus_wait_req;
   assign cycle_ready = finish;
   assign cycle_busy  = (state_reg == ST_WAIT);

   assign recovery_load = finish && (kind_reg == CYC_IO);

   bcw_down_counter u_recovery
   (
      .clock      (clock),
      .rst_n      (rst_n),
      .load       (recovery_load),
      .load_value (IO_RECOVERY_CNT),
      .zero       (recovery_zero),
      .count      (recovery_left)
   );

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
            if (cycle.start)
               state_next = ST_WAIT;
         ST_WAIT:
            if (finish)
               state_next = ST_IDLE;
         default:
            state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_reg       <= ST_IDLE;
         kind_reg        <= CYC_FETCH;
         recovery_on_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         if (cycle.start && state_reg == ST_IDLE)
         begin
            kind_reg        <= cycle.kind;
            recovery_on_reg <= jumpers.io_recovery;
         end
      end
   end

   // on-board port decode, six base bits pick a four-port group
   assign port_hit    = (io_addr[7:2] == onboard_port_base);
   assign latch_write = io_wr && port_hit && (io_addr[1:0] == PORT_LATCH_OFS);
   assign latch_read  = io_rd && port_hit && (io_addr[1:0] == PORT_LATCH_OFS);
   assign status_read = io_rd && port_hit && (io_addr[1:0] == PORT_STATUS_OFS);

   // clear beats a same-cycle write so reset leaves a known map
   assign latch_clear = power_on_clear || (!bus_reset_n && jumpers.latch_clear);

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         latch_reg <= LATCH_RESET;
      else if (latch_clear)
         latch_reg <= LATCH_RESET;
      else if (latch_write)
         latch_reg <= io_wr_data;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         rd_data_reg <= RD_DATA_RESET;
      else if (latch_read)
         rd_data_reg <= latch_reg;
      else if (status_read)
         rd_data_reg <= {2'h0, !recovery_zero, jumpers.io_recovery,
                         jumpers.extra_read, jumpers.latch_clear, jumpers.wait_b, jumpers.wait_a};
      else
         rd_data_reg <= RD_DATA_RESET;
   end

   assign io_rd_data = rd_data_reg;
   assign mm_latch   = latch_reg;

endmodule

// [bcw_wait_control_sva.sv]
// Purpose: port checks for the wait controller
// Assumes: jumpers steady around a cycle
// Notes: bound at the foot
`timescale 1ns/10ps
module bcw_wait_control_sva
   import bcw_pkg::*;
(
   input wire logic         clock,
   input wire logic         rst_n,
   input wire bcw_cycle_s   cycle,
   input wire logic         bus_wait_req,
   input wire logic         cycle_ready,
   input wire logic         cycle_busy,
   input wire bcw_jumpers_s jumpers,
   input wire logic         power_on_clear,
   input wire logic         bus_reset_n,
   input wire logic [5:0]   onboard_port_base,
   input wire logic [7:0]   io_addr,
   input wire logic [7:0]   io_wr_data,
   input wire logic         io_wr,
   input wire logic         io_rd,
   input wire logic [7:0]   io_rd_data,
   input wire logic [7:0]   mm_latch
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire logic take = cycle.start && !cycle_busy;
   wire logic free = cycle_ready || bus_wait_req;
   ready_in_busy_a: assert property (cycle_ready |-> cycle_busy) else $error("ready outside cycle");
   start_taken_a: assert property (take |=> cycle_busy) else $error("cycle not taken");
   fetch_none_a: assert property (take && cycle.kind == CYC_FETCH && !jumpers.wait_a && !jumpers.wait_b
      |=> free) else $error("fetch waited");
   fetch_two_a: assert property (take && cycle.kind == CYC_FETCH && jumpers.wait_a && jumpers.wait_b
      |=> !cycle_ready [*2] ##1 free) else $error("fetch waits not two");
   read_extra_a: assert property (take && cycle.kind == CYC_MEM_RD && jumpers.extra_read
      |=> !cycle_ready [*2]) else $error("read extra missing");
   read_plain_a: assert property (take && cycle.kind == CYC_MEM_RD && !jumpers.extra_read && !jumpers.wait_a
      |=> free) else $error("read waited");
   io_plain_a: assert property (take && cycle.kind == CYC_IO && !jumpers.io_recovery
      |=> free) else $error("io stretched");
   latch_clear_a: assert property (power_on_clear || (!bus_reset_n && jumpers.latch_clear)
      |=> mm_latch == LATCH_RESET) else $error("latch not cleared");
   latch_load_a: assert property (io_wr && io_addr == {onboard_port_base, PORT_LATCH_OFS} && bus_reset_n
      && !power_on_clear |=> mm_latch == $past(io_wr_data)) else $error("latch not loaded");
endmodule
bind bcw_wait_control bcw_wait_control_sva bcw_wait_control_sva_i (.*);

// [bcw_bus_board.sv]
// Purpose: far-side bus board asking for waits
// Assumes: stall set by the bench
// Notes: one wait per cycle at most
`timescale 1ns/10ps
module bcw_bus_board
   import bcw_pkg::*;
(
   input  wire logic       clock,
   input  wire bcw_cycle_s cycle,
   input  wire logic       cycle_busy,
   input  wire logic       stall,
   output logic            bus_wait_req
);
   // first cycle only, so waits never pile up
   always @(posedge clock)
      bus_wait_req <= stall && cycle.start && !cycle_busy;
endmodule

// [tb_top.sv]
// Purpose: self-checking bench for the wait controller
// Assumes: fixed 50-cycle recovery
// Notes: io reads cover the status and latch ports
`timescale 1ns/10ps
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin bad_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end
module tb_top;
   import bcw_pkg::*;
   logic         clock = 0, rst_n = 0, power_on_clear = 0, bus_reset_n = 1, io_wr = 0, io_rd = 0, stall = 0;
   logic         bus_wait_req, cycle_ready, cycle_busy;
   bcw_cycle_s   cycle = '0;
   bcw_jumpers_s jumpers = 5'h1F;
   logic [7:0]   io_addr = 8'h00, io_wr_data = 8'h00, mm_latch, io_rd_data;
   int           bad_count = 0, tests_run = 0, n;
   always #5 clock = ~clock;
   bcw_wait_control bcw_wait_control_i (.clock(clock), .rst_n(rst_n), .cycle(cycle), .bus_wait_req(bus_wait_req),
      .cycle_ready(cycle_ready), .cycle_busy(cycle_busy), .jumpers(jumpers), .power_on_clear(power_on_clear),
      .bus_reset_n(bus_reset_n), .onboard_port_base(6'h3F), .io_addr(io_addr), .io_wr_data(io_wr_data),
      .io_wr(io_wr), .io_rd(io_rd), .io_rd_data(io_rd_data), .mm_latch(mm_latch));
   bcw_bus_board bcw_bus_board_i (.clock(clock), .cycle(cycle), .cycle_busy(cycle_busy), .stall(stall),
      .bus_wait_req(bus_wait_req));
   task automatic run(input bcw_cycle_e k);
      @(posedge clock);
      cycle <= '{1'b1, k};
      @(posedge clock);
      cycle.start <= 1'b0;
      #1 n = 1;
      while (!cycle_ready && n < 200)
      begin
         @(posedge clock);
         #1 n++;
      end
      if (n >= 200)
      begin
         bad_count++;
         tally_and_finish;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
      @(posedge clock);
      {io_wr, io_addr, io_wr_data} <= {1'b1, a, d};
      @(posedge clock);
      io_wr <= 1'b0;
      #1 `CHK("latch", e, mm_latch)
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      {io_rd, io_addr} <= {1'b1, a};
      @(posedge clock);
      io_rd <= 1'b0;
      #1 `CHK("port read", e, io_rd_data)
   endtask
   task automatic t_waits;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clock) jumpers <= {i[1], i[0], 3'b000};
         run(CYC_FETCH); `CHK("fetch", 1 + i[1] + i[0], n)
         run(CYC_MEM_OTH); `CHK("mem", 1 + i[1], n)
         run(CYC_MEM_RD); `CHK("read", 1 + i[1], n)
      end
      @(posedge clock) jumpers <= 5'h14;
      run(CYC_MEM_RD); `CHK("read extra", 4, n)
      run(CYC_FETCH); `CHK("fetch extra", 2, n)
      @(posedge clock) {stall, jumpers} <= {1'b1, 5'h00};
      run(CYC_FETCH); `CHK("stall", 2, n)
      @(posedge clock) stall <= 1'b0;
   endtask
   task automatic t_io;
      @(posedge clock) jumpers <= 5'h01;
      run(CYC_IO); `CHK("io first", 1, n)
      run(CYC_IO); `CHK("io gap", 1'b1, n >= 49 && n <= 69)
      @(posedge clock) jumpers <= 5'h00;
      run(CYC_IO);
      run(CYC_IO); `CHK("io plain", 1, n)
      // recovery still counts after a plain cycle, status shows it
      rd(8'hFF, 8'h20);
   endtask
   task automatic t_latch;
      @(posedge clock) jumpers <= 5'h02;
      wr(8'hFD, 8'h5A, 8'h5A);
      wr(8'hFC, 8'hA5, 8'h5A);
      @(posedge clock) bus_reset_n <= 1'b0;
      @(posedge clock) bus_reset_n <= 1'b1;
      #1 `CHK("bus clear", 8'h00, mm_latch)
      wr(8'hFD, 8'h3C, 8'h3C);
      rd(8'hFD, 8'h3C);
      @(posedge clock) jumpers <= 5'h00;
      @(posedge clock) bus_reset_n <= 1'b0;
      @(posedge clock) {bus_reset_n, power_on_clear} <= 2'b11;
      #1 `CHK("kept", 8'h3C, mm_latch)
      @(posedge clock) power_on_clear <= 1'b0;
      #1 `CHK("power clear", 8'h00, mm_latch)
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      #1 `CHK("reset latch", LATCH_RESET, mm_latch)
      t_waits;
      t_io;
      t_latch;
      tally_and_finish;
   end
endmodule
